// ==== src/pas_pkg.sv ====
package pas_pkg;
    // Strobe timing in processor output clock cycles
    localparam int unsigned WR_DELAY_CYC = 2;
    localparam int unsigned STB_WIDTH_CYC = 2;
    localparam int unsigned RD_DELAY_CYC = 3;
    localparam int unsigned RD_LATCH_AGE = 3;
    localparam int unsigned CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] WR_LAST = 3'(WR_DELAY_CYC + STB_WIDTH_CYC - 1);
    localparam logic [CNT_W-1:0] WR_ON = 3'(WR_DELAY_CYC);
    localparam logic [CNT_W-1:0] RD_LAST = 3'(RD_DELAY_CYC + STB_WIDTH_CYC - 1);
    localparam logic [CNT_W-1:0] RD_ON = 3'(RD_DELAY_CYC);
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        PAS_IDLE,
        PAS_WRITE,
        PAS_READ
    } pas_state_t;

    typedef struct packed {
        logic memAccess;   // External data memory cycle active
        logic memRead;     // Read when set, write when clear
        logic usesSecond;  // Address from second auto-pointer
        logic [15:0] addr;
    } pas_mem_req_t;
endpackage : pas_pkg

// ==== src/pas_port_strobe.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Port strobe sequences start only while the strobe enable bit is set.
// - From idle, port read pulses read strobe, port write pulses write strobe; write wins if both.
// - Each strobe pulse lasts exactly two clock cycles.
// - Write strobe asserts two cycles after port output update, for two.
// - Read returns pin value latched three cycles before read strobe.
// - After a port read, wait three cycles then pulse read strobe for two.
// - Read strobe assertion causes no internal port sampling.
// - First auto-pointer address drives the bus only during a strobe.
// - Second auto-pointer address stays driven for the whole access cycle.
// - Memory cycle stretch lengthens data accesses only, never fetches.
module pas_port_strobe import pas_pkg::*; (
    input wire logic clk,                 // Processor output clock
    input wire logic rst_n,               // Async reset, active low
    input wire logic portStrobeEnable,    // Strobe enable control bit
    input wire logic portWrite,           // Processor writes port, pulse
    input wire logic [7:0] portWriteData, // Byte written by processor
    input wire logic portRead,            // Processor reads port, pulse
    input wire logic [7:0] portPinIn,     // Port pin levels
    input wire pas_mem_req_t memReq,      // External data memory cycle
    input wire logic memStrobeActive,     // Memory strobe phase of cycle
    input wire logic fetchCycle,          // Program fetch in progress
    input wire logic [1:0] stretchCfg,    // Data memory stretch setting
    output logic [7:0] portOut,           // Port output value
    output logic [7:0] portReadData,      // Byte returned to processor
    output logic rdStrobe_n,              // Read strobe pin
    output logic wrStrobe_n,              // Write strobe pin
    output logic [15:0] addrBus,          // External address bus
    output logic addrBusOe,               // Address bus driven
    output logic [1:0] activeStretch      // Stretch applied this cycle
);
    logic [7:0] pinSync1, pinSync2;
    logic [7:0] pinHist [RD_LATCH_AGE];
    pas_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [7:0] next_portOut, next_portReadData;
    logic next_rdStrobe_n, next_wrStrobe_n;

    // Pin synchroniser, then an age line the read-age check looks back along
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1 <= PORT_RESET;
            pinSync2 <= PORT_RESET;
        end else begin
            pinSync1 <= portPinIn;
            pinSync2 <= pinSync1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < RD_LATCH_AGE; g++) begin : gHist
            if (g == 0) begin : gFirst
                always_ff @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        pinHist[g] <= PORT_RESET;
                    end else begin
                        pinHist[g] <= pinSync2;
                    end
                end
            end else begin : gRest
                always_ff @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        pinHist[g] <= PORT_RESET;
                    end else begin
                        pinHist[g] <= pinHist[g-1];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_portOut = portOut;
        next_portReadData = portReadData;
        next_rdStrobe_n = 1'b1;
        next_wrStrobe_n = 1'b1;
        if (portWrite) begin
            next_portOut = portWriteData;
        end
        // The returned byte is captured at the read itself; the strobe
        // fires later and samples nothing
        if (portRead) begin
            next_portReadData = pinSync2;
        end
        unique case (state)
            PAS_IDLE: begin
                next_cnt = CNT_ONE;
                if (portWrite && portStrobeEnable) begin
                    next_state = PAS_WRITE;
                end else if (portRead && portStrobeEnable) begin
                    next_state = PAS_READ;
                end
            end
            PAS_WRITE: begin
                next_cnt = cnt + CNT_ONE;
                if (cnt >= WR_ON) begin
                    next_wrStrobe_n = 1'b0;
                end
                if (cnt == WR_LAST) begin
                    next_state = PAS_IDLE;
                end
            end
            PAS_READ: begin
                next_cnt = cnt + CNT_ONE;
                if (cnt >= RD_ON) begin
                    next_rdStrobe_n = 1'b0;
                end
                if (cnt == RD_LAST) begin
                    next_state = PAS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PAS_IDLE;
            cnt <= CNT_ZERO;
            portOut <= PORT_RESET;
            portReadData <= PORT_RESET;
            rdStrobe_n <= 1'b1;
            wrStrobe_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            portOut <= next_portOut;
            portReadData <= next_portReadData;
            rdStrobe_n <= next_rdStrobe_n;
            wrStrobe_n <= next_wrStrobe_n;
        end
    end

    // Address drive; the first pointer is gated to its strobe phase so the
    // bus stays quiet between strobes
    logic [15:0] next_addrBus;
    logic next_addrBusOe;
    logic [1:0] next_activeStretch;
    always_comb begin
        next_addrBus = addrBus;
        next_addrBusOe = 1'b0;
        if (memReq.memAccess) begin
            if (memReq.usesSecond) begin
                next_addrBusOe = 1'b1;
            end else begin
                next_addrBusOe = memStrobeActive;
            end
            next_addrBus = memReq.addr;
        end
        // Stretch never applies to fetches
        next_activeStretch = (memReq.memAccess && !fetchCycle) ?
            stretchCfg : 2'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addrBus <= ADDR_RESET;
            addrBusOe <= 1'b0;
            activeStretch <= 2'h0;
        end else begin
            addrBus <= next_addrBus;
            addrBusOe <= next_addrBusOe;
            activeStretch <= next_activeStretch;
        end
    end

    // Checks
    a_wr_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PAS_IDLE && portWrite && portStrobeEnable) |->
        ##1 wrStrobe_n ##1 wrStrobe_n ##1 !wrStrobe_n ##1 !wrStrobe_n
        ##1 wrStrobe_n)
        else $error("write strobe timing wrong");
    a_rd_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PAS_IDLE && portRead && portStrobeEnable && !portWrite)
        |-> ##1 rdStrobe_n [*3] ##1 !rdStrobe_n [*2] ##1 rdStrobe_n)
        else $error("read strobe timing wrong");
    a_no_enable: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PAS_IDLE && !portStrobeEnable) |=> state == PAS_IDLE)
        else $error("strobe started while disabled");
    a_width_two: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(rdStrobe_n) |-> ##1 !rdStrobe_n ##1 rdStrobe_n)
        else $error("strobe width not two");
    a_wr_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(wrStrobe_n) |-> ##1 !wrStrobe_n ##1 wrStrobe_n)
        else $error("write strobe width not two");
    a_not_both: assert property (@(posedge clk) disable iff (!rst_n)
        !(!rdStrobe_n && !wrStrobe_n))
        else $error("both strobes low");
    a_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PAS_IDLE && $past(state) == PAS_IDLE) |->
        (rdStrobe_n && wrStrobe_n))
        else $error("strobe low while idle");
    a_rd_data: assert property (@(posedge clk) disable iff (!rst_n)
        portRead |=> portReadData == $past(pinSync2))
        else $error("read data not captured");
    // Reads inside the strobe sequence refresh the byte, so skip those
    a_rd_age: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(rdStrobe_n) && !$past(portRead, 1) && !$past(portRead, 2)
        && !$past(portRead, 3)) |->
        portReadData == $past(pinHist[RD_LATCH_AGE-1]))
        else $error("read byte not three cycles older than strobe");
    a_rd_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!$past(portRead) && $fell(rdStrobe_n)) |-> $stable(portReadData))
        else $error("read strobe sampled port");
    a_ptr_one: assert property (@(posedge clk) disable iff (!rst_n)
        (memReq.memAccess && !memReq.usesSecond) |=>
        addrBusOe == $past(memStrobeActive))
        else $error("first pointer drive wrong");
    a_ptr_two: assert property (@(posedge clk) disable iff (!rst_n)
        (memReq.memAccess && memReq.usesSecond) |=> addrBusOe)
        else $error("second pointer not driven");
    a_fetch: assert property (@(posedge clk) disable iff (!rst_n)
        fetchCycle |=> activeStretch == 2'h0)
        else $error("fetch stretched");
    c_write: cover property (@(posedge clk) $fell(wrStrobe_n));
    c_disabled: cover property (@(posedge clk)
        portWrite && !portStrobeEnable);
    c_read: cover property (@(posedge clk) $fell(rdStrobe_n));
    c_second: cover property (@(posedge clk)
        memReq.memAccess && memReq.usesSecond);
endmodule : pas_port_strobe

// ==== tb/pas_periph_model.sv ====
`timescale 1ns/10ps
// Peripheral that offers its next byte only once a read strobe has ended
module pas_periph_model (
    input wire logic clk,         // Processor output clock
    input wire logic rst_n,       // Async reset, active low
    input wire logic rdStrobe_n,  // Read strobe from the port
    output logic [7:0] pinOut     // Byte driven onto the port pins
);
    logic rdLast;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdLast <= 1'b1;
            pinOut <= 8'ha5;
        end else begin
            rdLast <= rdStrobe_n;
            // Inverted byte makes a missed or early change easy to spot
            if (rdStrobe_n && !rdLast) begin
                pinOut <= ~pinOut;
            end
        end
    end
endmodule : pas_periph_model

// ==== tb/tb_port_access_strobe_logic.sv ====
`timescale 1ns/10ps
module tb_port_access_strobe_logic import pas_pkg::*;;
    logic clk, rst_n, en, wr, rd, fetch, memStb, rdN, wrN, oe;
    logic [7:0] wData, pin, pOut, rData, expPin;
    logic [15:0] addr;
    logic [1:0] stretch, actStr;
    pas_mem_req_t req;
    int errCount, nCompared;

    pas_port_strobe uut (.clk(clk), .rst_n(rst_n), .portStrobeEnable(en),
        .portWrite(wr), .portWriteData(wData), .portRead(rd),
        .portPinIn(pin), .memReq(req), .memStrobeActive(memStb),
        .fetchCycle(fetch), .stretchCfg(stretch), .portOut(pOut),
        .portReadData(rData), .rdStrobe_n(rdN), .wrStrobe_n(wrN),
        .addrBus(addr), .addrBusOe(oe), .activeStretch(actStr));
    pas_periph_model partner (.clk(clk), .rst_n(rst_n), .rdStrobe_n(rdN),
        .pinOut(pin));

    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One port access, then the strobes seen after each of six edges
    task automatic access(logic isWr, logic [7:0] d, output logic [5:0] sr,
            output logic [5:0] sw);
        @(posedge clk);
        wr <= isWr;
        rd <= !isWr;
        wData <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            #1;
            sr[i] = rdN;
            sw[i] = wrN;
            @(posedge clk);
        end
    endtask : access

    task automatic t_write();
        logic [5:0] r, w;
        access(1'b1, 8'h96, r, w);
        chk("wrStrobe_n", 16'(6'b110011), 16'(w));
        chk("rdStrobe_n", 16'(6'b111111), 16'(r));
        chk("portOut", 16'h0096, 16'(pOut));
    endtask : t_write

    task automatic t_read();
        logic [5:0] r, w;
        logic [7:0] e;
        e = expPin;
        access(1'b0, 8'h00, r, w);
        chk("rdStrobe_n", 16'(6'b100111), 16'(r));
        chk("wrStrobe_n", 16'(6'b111111), 16'(w));
        chk("portReadData", 16'(e), 16'(rData));
        expPin = ~e;
        repeat (4) @(posedge clk);
        chk("portReadData kept", 16'(e), 16'(rData));
    endtask : t_read

    task automatic t_off();
        logic [5:0] r, w;
        @(posedge clk);
        en <= 1'b0;
        access(1'b1, 8'h3c, r, w);
        chk("strobes off wr", 16'(6'b111111), 16'({r & w}));
        access(1'b0, 8'h00, r, w);
        chk("strobes off rd", 16'(6'b111111), 16'({r & w}));
        en <= 1'b1;
    endtask : t_off

    task automatic mem(logic sec, logic stb, logic f);
        @(posedge clk);
        req <= '{1'b1, 1'b1, sec, 16'h1234};
        memStb <= stb;
        fetch <= f;
        @(posedge clk);
        #1;
    endtask : mem

    task automatic t_mem();
        mem(1'b0, 1'b0, 1'b0);
        chk("addrBusOe first idle", 16'h0000, 16'(oe));
        chk("activeStretch data", 16'h0002, 16'(actStr));
        mem(1'b0, 1'b1, 1'b0);
        chk("addrBusOe first stb", 16'h0001, 16'(oe));
        chk("addrBus first", 16'h1234, addr);
        mem(1'b1, 1'b0, 1'b0);
        chk("addrBusOe second", 16'h0001, 16'(oe));
        chk("addrBus second", 16'h1234, addr);
        mem(1'b1, 1'b0, 1'b1);
        chk("activeStretch fetch", 16'h0000, 16'(actStr));
    endtask : t_mem

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        {rst_n, wr, rd, fetch, memStb, wData, req, stretch} = '0;
        en = 1'b1;
        stretch = 2'h2;
        expPin = 8'ha5;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_write();
        t_read();
        t_read();
        t_off();
        t_mem();
        complete_run();
    end

    // Whole run needs about 63 cycles
    initial begin
        #5000;
        errCount++;
        complete_run();
    end
endmodule : tb_port_access_strobe_logic
